// ==== logic/ccr_ctrl.sv ====
// Purpose: Status-word format decode, system-mask instructions, store
//          status dump and the four reset functions
// Assumes: Storage writes one doubleword per cycle without stall
// Notes: Register file holds 4 floats, 16 generals, 16 controls
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ccr_ctrl #(
	parameter int unsigned STORE_WORDS = 32'h0001_0000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Reset and store-status requests, one-cycle pulses
	input wire logic power_on_i,
	input wire logic sys_clear_i,
	input wire logic ipl_reset_i,
	input wire logic sys_reset_i,
	input wire logic store_status_i,
	// Status word load and mask instructions
	input wire logic psw_load_i,
	input wire logic [63:0] psw_i,
	input wire ccr_pkg::ccr_mask_op_s mask_op_i,
	// Register writes from the execution unit, then CPU address and channel inputs
	input wire logic cr_we_i,
	input wire logic [3:0] cr_idx_i,
	input wire logic [63:0] cr_data_i,
	input wire logic [23:0] cpu_addr_i,
	input wire logic cpu_addr_fixed_i,
	input wire logic chan_ida_i,
	// Control state outputs
	output logic basic_control_format_o,
	output logic extended_control_format_o,
	output logic per_enable_o,
	output logic conv_enable_o,
	output logic [15:0] io_enable_o,
	output logic [15:0] ext_enable_o,
	output logic chan_indirect_o,
	output logic special_op_exc_o,
	output logic [7:0] saved_mask_o,
	output logic cpu_stopped_o,
	output logic clear_pending_o,
	output logic ctl_store_load_o,
	output logic tod_clear_o,
	output logic operational_out_o,
	output ccr_pkg::ccr_store_s store_o,
	output logic [63:0] psw_o
);
	ccr_pkg::ccr_state_e state_r;
	logic [63:0] psw_r;
	logic [63:0] cr_r [16];
	logic [63:0] gpr_r [16];
	logic [63:0] fpr_r [4];
	logic [63:0] timer_r;
	logic [63:0] cmp_r;
	logic [2:0] pend_r;
	logic [2:0] kind_r;
	logic [15:0] cnt_r;
	logic [7:0] hold_r;
	logic [5:0] dump_r;

	function automatic logic psw_bit(input logic [63:0] w, input int b);
		return w[63 - b];
	endfunction

	function automatic logic [2:0] rank(input logic [2:0] a,
			input logic [2:0] b);
		return (a > b) ? a : b;
	endfunction

	wire logic ext_fmt = psw_bit(psw_r, ccr_pkg::FMT_BIT);
	wire logic [7:0] sysmask = psw_r[63:56];
	wire logic ssm_sup = psw_bit(cr_r[0], ccr_pkg::SSM_SUP_BIT + 32);

	logic [2:0] req;
	always_comb begin
		req = ccr_pkg::RST_NONE;
		if (sys_reset_i)
			req = rank(req, ccr_pkg::RST_SYS);
		if (ipl_reset_i)
			req = rank(req, ccr_pkg::RST_IPL);
		if (sys_clear_i)
			req = rank(req, ccr_pkg::RST_CLR);
		if (power_on_i)
			req = rank(req, ccr_pkg::RST_PON);
	end

	// Pulses that meet in one cycle merge, so each area changes once; a
	// request taken as a reset starts is kept for the following pass
	wire logic take_rst = (state_r == ccr_pkg::ST_RUN
		|| state_r == ccr_pkg::ST_STOP) && pend_r != ccr_pkg::RST_NONE;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_r <= ccr_pkg::RST_NONE;
		end else if (take_rst) begin
			pend_r <= req;
		end else begin
			pend_r <= rank(pend_r, req);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= ccr_pkg::ST_STOP;
			kind_r <= ccr_pkg::RST_NONE;
			cnt_r <= 16'h0000;
			dump_r <= 6'h00;
		end else begin
			case (state_r)
			ccr_pkg::ST_RUN, ccr_pkg::ST_STOP: begin
				if (pend_r != ccr_pkg::RST_NONE) begin
					state_r <= ccr_pkg::ST_RESET;
					kind_r <= pend_r;
				end else if (store_status_i) begin
					state_r <= ccr_pkg::ST_DUMP;
					dump_r <= 6'h00;
				end else if (psw_load_i) begin
					state_r <= ccr_pkg::ST_RUN;
				end
			end
			ccr_pkg::ST_RESET: begin
				cnt_r <= 16'h0000;
				if (kind_r >= ccr_pkg::RST_CLR)
					state_r <= ccr_pkg::ST_CLEAR;
				else
					state_r <= ccr_pkg::ST_STOP;
			end
			ccr_pkg::ST_CLEAR: begin
				cnt_r <= cnt_r + 16'h0001;
				if (32'(cnt_r) == STORE_WORDS - 1)
					state_r <= ccr_pkg::ST_STOP;
			end
			ccr_pkg::ST_DUMP: begin
				dump_r <= dump_r + 6'h01;
				if (dump_r == 6'h26)
					state_r <= ccr_pkg::ST_STOP;
			end
			default: state_r <= ccr_pkg::ST_STOP;
			endcase
		end
	end

	wire logic in_reset = state_r == ccr_pkg::ST_RESET;
	wire logic zero_regs = in_reset && kind_r >= ccr_pkg::RST_CLR;
	wire logic zero_psw = in_reset && kind_r >= ccr_pkg::RST_IPL;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			psw_r <= 64'h0;
			special_op_exc_o <= 1'b0;
			saved_mask_o <= 8'h00;
		end else begin
			special_op_exc_o <= 1'b0;
			if (zero_psw) begin
				psw_r <= 64'h0;
			end else if (state_r == ccr_pkg::ST_RUN) begin
				if (psw_load_i) begin
					psw_r <= psw_i;
				end else if (mask_op_i.ssm) begin
					if (ssm_sup)
						special_op_exc_o <= 1'b1;
					else
						psw_r[63:56] <= mask_op_i.imm;
				end else if (mask_op_i.stnsm) begin
					saved_mask_o <= sysmask;
					psw_r[63:56] <= sysmask & mask_op_i.imm;
				end else if (mask_op_i.stosm) begin
					saved_mask_o <= sysmask;
					psw_r[63:56] <= sysmask | mask_op_i.imm;
				end
			end else if (psw_load_i) begin
				psw_r <= psw_i;
			end
		end
	end

	// System reset leaves registers untouched; load reset only controls, timer and comparator
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < 16; i++) begin
				cr_r[i] <= 64'h0;
				gpr_r[i] <= 64'h0;
			end
			for (int i = 0; i < 4; i++)
				fpr_r[i] <= 64'h0;
			timer_r <= 64'h0;
			cmp_r <= 64'h0;
		end else if (in_reset && kind_r >= ccr_pkg::RST_IPL) begin
			for (int i = 0; i < 16; i++)
				cr_r[i] <= 64'h0;
			cr_r[0] <= ccr_pkg::CR0_INIT;
			cr_r[14] <= ccr_pkg::CR14_INIT;
			timer_r <= 64'h0;
			cmp_r <= 64'h0;
			if (zero_regs) begin
				for (int i = 0; i < 16; i++)
					gpr_r[i] <= 64'h0;
				for (int i = 0; i < 4; i++)
					fpr_r[i] <= 64'h0;
			end
		end else if (cr_we_i) begin
			cr_r[cr_idx_i] <= cr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			store_o <= '0;
		end else if (state_r == ccr_pkg::ST_CLEAR) begin
			store_o.we <= 1'b1;
			store_o.addr <= cnt_r[8:0];
			store_o.data <= 64'h0;
		end else if (state_r == ccr_pkg::ST_DUMP) begin
			store_o.we <= 1'b1;
			if (dump_r == 6'h00) begin
				store_o.addr <= ccr_pkg::ADR_TIMER;
				store_o.data <= timer_r;
			end else if (dump_r == 6'h01) begin
				store_o.addr <= ccr_pkg::ADR_CMP;
				store_o.data <= cmp_r;
			end else if (dump_r == 6'h02) begin
				store_o.addr <= ccr_pkg::ADR_PSW;
				store_o.data <= psw_r;
			end else if (dump_r < 6'h07) begin
				store_o.addr <= ccr_pkg::ADR_FPR + {dump_r - 6'h03, 3'b000};
				store_o.data <= fpr_r[2'(dump_r - 6'h03)];
			end else if (dump_r < 6'h17) begin
				store_o.addr <= ccr_pkg::ADR_GPR + {dump_r - 6'h07, 3'b000};
				store_o.data <= gpr_r[4'(dump_r - 6'h07)];
			end else begin
				store_o.addr <= ccr_pkg::ADR_CR + {dump_r - 6'h17, 3'b000};
				store_o.data <= cr_r[4'(dump_r - 6'h17)];
			end
		end else begin
			store_o <= '0;
		end
	end

	// Operational-out stays low a few cycles so control units see it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_r <= ccr_pkg::OPOUT_HOLD;
			operational_out_o <= 1'b0;
		end else if (in_reset) begin
			hold_r <= ccr_pkg::OPOUT_HOLD;
			operational_out_o <= 1'b0;
		end else if (hold_r != 8'h00) begin
			hold_r <= hold_r - 8'h01;
			operational_out_o <= 1'b0;
		end else begin
			operational_out_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			basic_control_format_o <= 1'b1;
			extended_control_format_o <= 1'b0;
			per_enable_o <= 1'b0;
			conv_enable_o <= 1'b0;
			io_enable_o <= 16'h0000;
			ext_enable_o <= 16'h0000;
			chan_indirect_o <= 1'b0;
			cpu_stopped_o <= 1'b1;
			clear_pending_o <= 1'b0;
			ctl_store_load_o <= 1'b0;
			tod_clear_o <= 1'b0;
			psw_o <= 64'h0;
		end else begin
			basic_control_format_o <= !ext_fmt;
			extended_control_format_o <= ext_fmt;
			per_enable_o <= ext_fmt && psw_bit(psw_r, ccr_pkg::PER_BIT);
			conv_enable_o <= ext_fmt && psw_bit(psw_r, ccr_pkg::XLATE_BIT)
				&& !cpu_addr_fixed_i && cpu_addr_i != 24'h0;
			io_enable_o <= {16{ext_fmt && psw_bit(psw_r, ccr_pkg::IO_BIT)}}
				& cr_r[2][63:48];
			ext_enable_o <= {16{ext_fmt && psw_bit(psw_r, ccr_pkg::EXT_BIT)}}
				& cr_r[0][47:32];
			chan_indirect_o <= chan_ida_i;
			cpu_stopped_o <= state_r != ccr_pkg::ST_RUN;
			clear_pending_o <= in_reset;
			ctl_store_load_o <= in_reset && kind_r == ccr_pkg::RST_PON;
			tod_clear_o <= in_reset && kind_r == ccr_pkg::RST_PON;
			psw_o <= psw_r;
		end
	end

	AST_STOP_AFTER_RESET: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) in_reset |=> ##1 cpu_stopped_o)
		else $error("CPU not stopped after reset");
	AST_OPOUT_DROP: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) in_reset |=> !operational_out_o)
		else $error("operational-out not dropped");
	AST_SSM_SUPPRESS: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) state_r == ccr_pkg::ST_RUN && !psw_load_i
		&& mask_op_i.ssm && ssm_sup |=> special_op_exc_o
		&& $stable(psw_r))
		else $error("set mask not suppressed");
	AST_BASIC_NO_PER: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) !ext_fmt |=> !per_enable_o)
		else $error("event recording in basic format");
	AST_BASIC_NO_CONV: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) !ext_fmt |=> !conv_enable_o)
		else $error("address conversion in basic format");
	AST_FIXED_NO_CONV: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) cpu_addr_fixed_i |=> !conv_enable_o)
		else $error("fixed address converted");
	AST_BASIC_NO_MASK: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) !ext_fmt |=> io_enable_o == 16'h0000
		&& ext_enable_o == 16'h0000)
		else $error("master masks open in basic format");
	AST_IDA_PASS: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) 1'b1
		|=> chan_indirect_o == $past(chan_ida_i))
		else $error("indirect addressing flag gated");
	AST_PSW_ZERO: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) zero_psw |=> psw_r == 64'h0)
		else $error("status word not zeroed");
	AST_SYS_KEEP_PSW: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) in_reset && kind_r == ccr_pkg::RST_SYS
		&& !psw_load_i |=> $stable(psw_r))
		else $error("status word changed by system reset");
	AST_TOD_KEEP: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) in_reset && kind_r != ccr_pkg::RST_PON
		|=> !tod_clear_o)
		else $error("clock cleared by lesser reset");
	AST_DUMP_PSW: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) state_r == ccr_pkg::ST_DUMP
		&& dump_r == 6'h02 |=> store_o.addr == ccr_pkg::ADR_PSW)
		else $error("status word stored at wrong address");
	AST_STNSM: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) state_r == ccr_pkg::ST_RUN && !zero_psw
		&& !psw_load_i && !mask_op_i.ssm && mask_op_i.stnsm
		|=> (psw_r[63:56] & ~$past(mask_op_i.imm)) == 8'h00)
		else $error("mask bits not cleared");
	AST_STOSM: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) state_r == ccr_pkg::ST_RUN
		&& !psw_load_i && !mask_op_i.ssm && !mask_op_i.stnsm
		&& mask_op_i.stosm
		|=> (psw_r[63:56] & $past(mask_op_i.imm))
		== $past(mask_op_i.imm))
		else $error("mask bits not set");
	COV_IPL: cover property (@(posedge clk_i) in_reset
		&& kind_r == ccr_pkg::RST_IPL);
	COV_CLEAR: cover property (@(posedge clk_i)
		state_r == ccr_pkg::ST_CLEAR);
	COV_DUMP: cover property (@(posedge clk_i)
		state_r == ccr_pkg::ST_DUMP);
	COV_STOSM: cover property (@(posedge clk_i) mask_op_i.stosm
		&& state_r == ccr_pkg::ST_RUN);
	COV_SSM_SUP: cover property (@(posedge clk_i) special_op_exc_o);
endmodule
`default_nettype wire

// ==== logic/ccr_pkg.sv ====
// Purpose: Constants and types for the CPU control-state and reset block
// Assumes: 64-bit status word, bit 0 is the most significant bit
package ccr_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned PSW_W = 64;
	localparam int unsigned FMT_BIT = 12;
	localparam int unsigned PER_BIT = 1;
	localparam int unsigned XLATE_BIT = 5;
	localparam int unsigned IO_BIT = 6;
	localparam int unsigned EXT_BIT = 7;
	localparam int unsigned SSM_SUP_BIT = 1;
	localparam logic [8:0] ADR_TIMER = 9'h0D8;
	localparam logic [8:0] ADR_CMP = 9'h0E0;
	localparam logic [8:0] ADR_PSW = 9'h100;
	localparam logic [8:0] ADR_FPR = 9'h160;
	localparam logic [8:0] ADR_GPR = 9'h180;
	localparam logic [8:0] ADR_CR = 9'h1C0;
	localparam logic [8:0] LOW_LIMIT = 9'h1FF;
	localparam logic [3:0] N_FPR = 4'h4;
	localparam logic [4:0] N_GPR = 5'h10;
	localparam logic [4:0] N_CR = 5'h10;
	localparam logic [63:0] CR0_INIT = 64'h0000_0000_E000_0000;
	localparam logic [63:0] CR14_INIT = 64'h0000_0000_C200_0000;
	localparam logic [7:0] OPOUT_HOLD = 8'h08;
	localparam logic [2:0] RST_NONE = 3'h0;
	localparam logic [2:0] RST_SYS = 3'h1;
	localparam logic [2:0] RST_IPL = 3'h2;
	localparam logic [2:0] RST_CLR = 3'h3;
	localparam logic [2:0] RST_PON = 3'h4;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_RESET = 3'b001,
		ST_CLEAR = 3'b010,
		ST_STOP = 3'b011,
		ST_DUMP = 3'b100
	} ccr_state_e;
	typedef struct packed {
		logic we;
		logic [8:0] addr;
		logic [63:0] data;
	} ccr_store_s;
	typedef struct packed {
		logic ssm;
		logic stnsm;
		logic stosm;
		logic [7:0] imm;
	} ccr_mask_op_s;
endpackage

// ==== test/ccr_ctrl_bench.sv ====
// Purpose: Self-checking bench for the control-state and reset block
// Assumes: Levels settle within three cycles of their cause
// Notes: Clear and dump writes are matched in order against a queue
`timescale 1ns/1ps
`default_nettype none
module ccr_ctrl_bench;
	localparam int SW = 16;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [4:0] req = 5'h00;
	logic psw_load_i = 1'b0, cr_we_i = 1'b0, fix = 1'b0, ida = 1'b0;
	logic [63:0] psw_i = '0, cr_data_i = '0, p, c0, c2, rd, psw_o;
	logic [3:0] cr_idx_i = 4'h0;
	logic [23:0] cpu_addr_i = 24'h000000;
	ccr_pkg::ccr_mask_op_s mop = '0;
	ccr_pkg::ccr_store_s st;
	logic bf, ef, program_event_recording, conv, cind, exc, stp, clr, csl, time_of_day_clock, opo;
	logic [15:0] ioe, exe;
	logic [7:0] sav, nres;
	logic [72:0] q[$];
	logic [72:0] nx;
	logic [63:0] crm [16];
	int err_count = 0, num_checks = 0, cyc = 0;
	int n_tod = 0, n_csl = 0, n_clr = 0, n_exc = 0;
	initial forever #50 clk_i = ~clk_i;
	ccr_ctrl #(.STORE_WORDS(SW)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.power_on_i(req[4]), .sys_clear_i(req[3]), .ipl_reset_i(req[2]),
		.sys_reset_i(req[1]), .store_status_i(req[0]),
		.psw_load_i(psw_load_i), .psw_i(psw_i), .mask_op_i(mop),
		.cr_we_i(cr_we_i), .cr_idx_i(cr_idx_i), .cr_data_i(cr_data_i),
		.cpu_addr_i(cpu_addr_i), .cpu_addr_fixed_i(fix), .chan_ida_i(ida),
		.basic_control_format_o(bf), .extended_control_format_o(ef),
		.per_enable_o(program_event_recording), .conv_enable_o(conv), .io_enable_o(ioe),
		.ext_enable_o(exe), .chan_indirect_o(cind), .special_op_exc_o(exc),
		.saved_mask_o(sav), .cpu_stopped_o(stp), .clear_pending_o(clr),
		.ctl_store_load_o(csl), .tod_clear_o(time_of_day_clock), .operational_out_o(opo),
		.store_o(st), .psw_o(psw_o));
	ccr_store_model sm (.clk_i(clk_i), .store_i(st), .operational_out_i(opo),
		.rd_idx_i(6'h20), .rd_data_o(rd), .chan_resets_o(nres));
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_st(input logic [72:0] e, input logic [72:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected store expected %h seen %h", e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic rq(input logic [4:0] r);
		req <= r;
		step(1);
		req <= 5'h00;
		step(1);
	endtask
	task automatic wcr(input logic [3:0] i, input logic [63:0] d);
		cr_idx_i <= i;
		cr_data_i <= d;
		cr_we_i <= 1'b1;
		step(1);
		cr_we_i <= 1'b0;
		crm[i] = d;
		step(1);
	endtask
	task automatic lp(input logic [63:0] v);
		psw_i <= v;
		psw_load_i <= 1'b1;
		step(1);
		psw_load_i <= 1'b0;
		p = v;
		step(3);
	endtask
	task automatic mo(input logic [2:0] o, input logic [7:0] m);
		mop <= {o, m};
		step(1);
		mop <= '0;
		step(3);
	endtask
	task automatic crinit();
		foreach (crm[i]) crm[i] = 64'h0;
		crm[0] = ccr_pkg::CR0_INIT;
		crm[14] = ccr_pkg::CR14_INIT;
	endtask
	task automatic pz();
		for (int i = 0; i < SW; i++) q.push_back({9'(i), 64'h0});
	endtask
	// Sampling before the edge's updates land keeps the watcher race free
	always @(posedge clk_i) begin
		cyc++;
		if (st.we === 1'b1) begin
			nx = q.size() ? q.pop_front() : 'x;
			chk_st(nx, st[72:0]);
		end
		if (arst_n_i) begin
			n_tod += (time_of_day_clock === 1'b1);
			n_csl += (csl === 1'b1);
			n_clr += (clr === 1'b1);
			n_exc += (exc === 1'b1);
		end
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(34900));
		step(2);
		chk("stopped", 1, stp);
		chk("basic", 1, bf);
		chk("opout", 0, opo);
		arst_n_i <= 1'b1;
		step(15);
		crinit();
		pz();
		// Power-on and load reset together must act once, as power-on
		rq(5'h14);
		step(30);
		chk("tod", 1, n_tod);
		chk("ctlload", 1, n_csl);
		chk("clrpend", 1, n_clr);
		chk("chanrst", 1, nres);
		chk("opout", 1, opo);
		chk("left", 0, q.size());
		for (int i = 0; i < 8; i++) begin
			c0 = {$urandom, $urandom} & ~64'h4000_0000;
			c2 = {$urandom, $urandom};
			wcr(4'h0, c0);
			wcr(4'h2, c2);
			cpu_addr_i <= 24'($urandom % 3);
			fix <= i[0];
			ida <= i[1];
			lp({$urandom, $urandom});
			chk("basic", !p[51], bf);
			chk("ext", p[51], ef);
			chk("per", p[51] & p[62], program_event_recording);
			chk("conv", p[51] & p[58] & !fix & |cpu_addr_i, conv);
			chk("ida", ida, cind);
			if (p[51]) begin
				chk("io", p[57] ? c2[63:48] : 16'h0, ioe);
				chk("xm", p[56] ? c0[47:32] : 16'h0, exe);
			end else begin
				chk("io0", 0, ioe);
				chk("xm0", 0, exe);
			end
		end
		lp(64'h5A08_0000_0000_1000);
		mo(3'b100, 8'hA5);
		chk("ssm", {8'hA5, p[55:0]}, psw_o);
		mo(3'b010, 8'h0F);
		chk("save", 8'hA5, sav);
		chk("andm", {8'h05, p[55:0]}, psw_o);
		mo(3'b001, 8'hC0);
		chk("save", 8'h05, sav);
		chk("orm", {8'hC5, p[55:0]}, psw_o);
		p[63:56] = 8'hC5;
		wcr(4'h0, c0 | 64'h4000_0000);
		mo(3'b100, 8'h11);
		chk("exc", 1, n_exc);
		chk("sup", p, psw_o);
		q.push_back({ccr_pkg::ADR_TIMER, 64'h0});
		q.push_back({ccr_pkg::ADR_CMP, 64'h0});
		q.push_back({ccr_pkg::ADR_PSW, p});
		for (int i = 0; i < 4; i++) q.push_back({ccr_pkg::ADR_FPR + 9'(8 * i), 64'h0});
		for (int i = 0; i < 16; i++) q.push_back({ccr_pkg::ADR_GPR + 9'(8 * i), 64'h0});
		for (int i = 0; i < 16; i++) q.push_back({ccr_pkg::ADR_CR + 9'(8 * i), crm[i]});
		rq(5'h01);
		step(45);
		chk("left", 0, q.size());
		chk("mem", p, rd);
		rq(5'h04);
		step(15);
		chk("psw", 0, psw_o);
		chk("tod", 1, n_tod);
		chk("chanrst", 2, nres);
		lp(64'h0008_0000_0000_00F0);
		rq(5'h02);
		step(15);
		chk("psw", p, psw_o);
		chk("stopped", 1, stp);
		chk("clrpend", 3, n_clr);
		pz();
		rq(5'h08);
		step(30);
		chk("tod", 1, n_tod);
		chk("ctlload", 1, n_csl);
		chk("psw", 0, psw_o);
		chk("left", 0, q.size());
		chk("chanrst", 4, nres);
		print_verdict();
	end
endmodule
`default_nettype wire

// ==== test/ccr_store_model.sv ====
// Purpose: Processor storage and channel side of the control-state block
// Assumes: Storage takes one doubleword a cycle and never stalls
// Notes: Channel counts each drop of operational-out as a reset
`timescale 1ns/1ps
`default_nettype none
module ccr_store_model (
	// Clock
	input wire logic clk_i,
	// Block side
	input wire ccr_pkg::ccr_store_s store_i,
	input wire logic operational_out_i,
	// Observation
	input wire logic [5:0] rd_idx_i,
	output logic [63:0] rd_data_o,
	output logic [7:0] chan_resets_o
);
	logic [63:0] mem_r [64];
	logic op_q_r = 1'b0;
	logic [7:0] resets_r = 8'h00;
	// Doubleword granular storage, indexed by address bits 8:3
	always @(posedge clk_i) begin
		if (store_i.we === 1'b1) begin
			mem_r[store_i.addr[8:3]] <= store_i.data;
		end
		op_q_r <= operational_out_i;
		// A control unit takes the falling edge as system reset
		if (op_q_r && !operational_out_i) begin
			resets_r <= resets_r + 8'h01;
		end
	end
	assign rd_data_o = mem_r[rd_idx_i];
	assign chan_resets_o = resets_r;
endmodule
`default_nettype wire
